// file: chsec_pkg.sv
package chsec_pkg;

  // ****************************************
  // management addressing
  // ****************************************
  localparam logic [4:0] CHSEC_DEV_ADDR = 5'h1E;
  localparam logic [15:0] CHSEC_OFF_STATUS = 16'h000F;
  localparam logic [15:0] CHSEC_OFF_HS_CNT = 16'h0010;
  localparam logic [15:0] CHSEC_OFF_LN0_CNT = 16'h0011;
  localparam logic [15:0] CHSEC_OFF_LN1_CNT = 16'h0012;
  localparam logic [15:0] CHSEC_UNMAPPED_DATA = 16'h0000;

  // ****************************************
  // reset and clear values
  // ****************************************
  localparam logic [15:0] CHSEC_STATUS_RST = 16'h0000;
  localparam logic [15:0] CHSEC_HS_CNT_RST = 16'h0000;
  localparam logic [15:0] CHSEC_LN_CNT_RST = 16'hFFFD;
  localparam logic [15:0] CHSEC_CNT_CLEAR = 16'h0000;

  // ****************************************
  // status word layout
  // ****************************************
  localparam int CHSEC_BIT_LANE_ALIGN = 14;
  localparam int CHSEC_BIT_SIG_LOST = 13;
  localparam int CHSEC_BIT_AZ_DONE = 12;
  localparam int CHSEC_BIT_GAIN_LOCK = 11;
  localparam int CHSEC_BIT_HS_SYNC = 10;
  localparam int CHSEC_BIT_BAD_CODE = 8;
  localparam int CHSEC_BIT_TX_UNDER = 7;
  localparam int CHSEC_BIT_TX_OVER = 6;
  localparam int CHSEC_BIT_RX_UNDER = 5;
  localparam int CHSEC_BIT_RX_OVER = 4;
  localparam int CHSEC_BIT_LS_LOCK = 1;
  localparam int CHSEC_BIT_HS_LOCK = 0;
  localparam logic [15:0] CHSEC_LH_MASK = 16'h21F1;
  localparam logic [15:0] CHSEC_LL_MASK = 16'h5C02;

  // ****************************************
  // pattern select and frame timing
  // ****************************************
  localparam logic [2:0] CHSEC_PAT_SEL_MIN = 3'h5;
  localparam logic [5:0] CHSEC_PRE_LEN = 6'h20;
  localparam logic [5:0] CHSEC_HDR_BITS = 6'h0E;
  localparam logic [5:0] CHSEC_TA_BITS = 6'h02;
  localparam logic [5:0] CHSEC_DATA_BITS = 6'h10;
  localparam logic [1:0] CHSEC_ST_C45 = 2'h0;
  localparam logic [1:0] CHSEC_OP_ADDR = 2'h0;
  localparam logic [1:0] CHSEC_OP_WRITE = 2'h1;
  localparam logic [1:0] CHSEC_OP_READ_INC = 2'h2;
  localparam logic [1:0] CHSEC_OP_READ = 2'h3;

  typedef enum logic [3:0] {
    CHSEC_ST_PRE = 4'h1,
    CHSEC_ST_HDR = 4'h2,
    CHSEC_ST_TA = 4'h4,
    CHSEC_ST_DATA = 4'h8
  } chsec_state_e;

  typedef struct packed {
    chsec_state_e state;
    logic mdc_q;
    logic [5:0] cnt;
    logic [13:0] hdr;
    logic [15:0] addr;
    logic [15:0] shift;
    logic is_rd;
    logic is_addr;
    logic dout;
    logic oe_n;
    logic ber_clr;
  } chsec_mdio_s;

endpackage

// file: chsec_latch_bit.sv
`timescale 1ns/1ps
module chsec_latch_bit #(
  parameter bit LATCH_HIGH = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic live,
  input wire logic rd,
  output logic q
);
  import chsec_pkg::*;

  typedef struct packed {
    logic val;
  } chsec_latch_s;

  chsec_latch_s r_ff;
  chsec_latch_s nxt_r;

  // a read releases the hold; the live value seen in that cycle still counts
  always_comb begin
    nxt_r = r_ff;
    if (ce) begin
      if (rd) begin
        nxt_r.val = live;
      end else if (LATCH_HIGH) begin
        nxt_r.val = r_ff.val | live;
      end else begin
        nxt_r.val = r_ff.val & live;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign q = r_ff.val;

  property p_latch_hold;
    @(posedge core_clk) disable iff (rst)
      (ce && !rd && (live == LATCH_HIGH)) |=> (q == LATCH_HIGH);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched level not held");

  property p_latch_release;
    @(posedge core_clk) disable iff (rst)
      (ce && rd) |=> (q == $past(live));
  endproperty
  a_latch_release: assert property (p_latch_release) else $error("read did not release latch");

endmodule

// file: chsec_err_counter.sv
`timescale 1ns/1ps
module chsec_err_counter #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic inc,
  input wire logic rd,
  output logic [WIDTH-1:0] q
);
  import chsec_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } chsec_cnt_s;

  localparam logic [WIDTH-1:0] CNT_MAX = '1;

  chsec_cnt_s r_ff;
  chsec_cnt_s nxt_r;

  always_comb begin
    nxt_r = r_ff;
    if (ce) begin
      if (rd) begin
        // error arriving with the read lands after the clear
        nxt_r.cnt = {{(WIDTH-1){1'b0}}, inc};
      end else if (inc && (r_ff.cnt != CNT_MAX)) begin
        nxt_r.cnt = r_ff.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_ff.cnt <= RST_VAL;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign q = r_ff.cnt;

  property p_clear_on_read;
    @(posedge core_clk) disable iff (rst)
      (ce && rd && !inc) |=> (q == CHSEC_CNT_CLEAR[WIDTH-1:0]);
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("counter not cleared by read");

  property p_read_and_error;
    @(posedge core_clk) disable iff (rst)
      (ce && rd && inc) |=> (q == {{(WIDTH-1){1'b0}}, 1'b1});
  endproperty
  a_read_and_error: assert property (p_read_and_error) else $error("error lost during read");

  property p_saturate;
    @(posedge core_clk) disable iff (rst)
      (ce && !rd && inc && (q == CNT_MAX)) |=> (q == CNT_MAX);
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter wrapped");

endmodule

// file: chsec_status_counters.sv
`timescale 1ns/1ps
// Functional notes
// - bit 14 lane aligned, latched low
// - bit 13 signal loss, latched high
// - bit 12 auto-zero done, latched low
// - bit 11 gain loop locked, latched low
// - bit 10 high side sync, latched low
// - bit 8 bad codeword, latched high
// - bits 7/6 transmit fifo under/overflow latched
// - bits 5/4 receive fifo under/overflow latched
// - bit 1 low side synth lock, latch-low
// - bit 0 high side synth lock, latch-high
// - high counter read clears external error byte
// - verify mode counts selected pattern errors
// - pseudo-random pin counts pattern errors
// - every counter clears when read
// - lane counters count bad codewords functionally
// - low verify mode counts lane pattern errors
// - lane counters at 0x11/0x12, reset 0xFFFD
// - status 0x0F, high counter 0x10, reset zero
// - high verify active only while enabled
// - low verify active only while enabled
module chsec_status_counters #(
  parameter logic [4:0] PORT_ADDR = 5'h00,
  parameter int LANES = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic low_side_lane_aligned,
  input wire logic high_side_signal_lost,
  input wire logic auto_zero_complete,
  input wire logic gain_loop_locked,
  input wire logic high_side_sync_achieved,
  input wire logic high_side_bad_codeword,
  input wire logic tx_ctc_underflow,
  input wire logic tx_ctc_overflow,
  input wire logic rx_ctc_underflow,
  input wire logic rx_ctc_overflow,
  input wire logic low_side_synth_locked,
  input wire logic high_side_synth_locked,
  input wire logic high_side_pattern_check_on,
  input wire logic [2:0] hs_pattern_sel,
  input wire logic hs_pattern_error,
  input wire logic pseudo_random_test_pin,
  input wire logic low_side_pattern_check_on,
  input wire logic [2:0] ls_pattern_sel,
  input wire logic [LANES-1:0] lane_bad_codeword,
  input wire logic [LANES-1:0] lane_pattern_error,
  output logic hs_ber_clear
);
  import chsec_pkg::*;

  // ****************************************
  // state and decode signals
  // ****************************************
  localparam chsec_mdio_s MDIO_RST = '{
    state: CHSEC_ST_PRE, mdc_q: 1'b0, cnt: 6'h00, hdr: 14'h0000, addr: 16'h0000,
    shift: 16'h0000, is_rd: 1'b0, is_addr: 1'b0, dout: 1'b0, oe_n: 1'b1, ber_clr: 1'b0};
  chsec_mdio_s r_ff;
  chsec_mdio_s nxt_r;
  logic mdc_rise;
  logic [13:0] hdr_shifted;
  logic [1:0] hdr_st;
  logic [1:0] hdr_op;
  logic hdr_mine;
  logic [15:0] rd_word;
  logic rd_status;
  logic rd_hs;
  logic [LANES-1:0] rd_lane;
  logic [15:0] status_live;
  logic [15:0] status_q;
  logic hs_err;
  logic hs_pat_valid;
  logic ls_pat_valid;
  logic [LANES-1:0] lane_err;
  logic [15:0] hs_cnt;
  logic [15:0] lane_cnt [LANES];

  // ****************************************
  // status word
  // ****************************************
  // reserved positions stay zero so they read back as zero
  always_comb begin
    status_live = CHSEC_STATUS_RST;
    status_live[CHSEC_BIT_LANE_ALIGN] = low_side_lane_aligned;
    status_live[CHSEC_BIT_SIG_LOST] = high_side_signal_lost;
    status_live[CHSEC_BIT_AZ_DONE] = auto_zero_complete;
    status_live[CHSEC_BIT_GAIN_LOCK] = gain_loop_locked;
    status_live[CHSEC_BIT_HS_SYNC] = high_side_sync_achieved;
    status_live[CHSEC_BIT_BAD_CODE] = high_side_bad_codeword;
    status_live[CHSEC_BIT_TX_UNDER] = tx_ctc_underflow;
    status_live[CHSEC_BIT_TX_OVER] = tx_ctc_overflow;
    status_live[CHSEC_BIT_RX_UNDER] = rx_ctc_underflow;
    status_live[CHSEC_BIT_RX_OVER] = rx_ctc_overflow;
    status_live[CHSEC_BIT_LS_LOCK] = low_side_synth_locked;
    status_live[CHSEC_BIT_HS_LOCK] = high_side_synth_locked;
  end
  for (genvar i = 0; i < 16; i++) begin : g_status
    if (CHSEC_LH_MASK[i] || CHSEC_LL_MASK[i]) begin : g_latch
      chsec_latch_bit #(
        .LATCH_HIGH(CHSEC_LH_MASK[i])
      ) u_bit (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .live(status_live[i]),
        .rd(rd_status),
        .q(status_q[i])
      );
    end else begin : g_zero
      assign status_q[i] = 1'b0;
    end
  end

  // ****************************************
  // error counters
  // ****************************************
  // in verify mode with the pseudo-random pin low, unlisted select codes have no checker, so nothing is counted then
  assign hs_pat_valid = hs_pattern_sel >= CHSEC_PAT_SEL_MIN;
  assign ls_pat_valid = ls_pattern_sel >= CHSEC_PAT_SEL_MIN;
  always_comb begin
    if (pseudo_random_test_pin) begin
      hs_err = hs_pattern_error;
    end else if (high_side_pattern_check_on) begin
      hs_err = hs_pat_valid && hs_pattern_error;
    end else begin
      hs_err = high_side_bad_codeword;
    end
  end
  chsec_err_counter #(
    .WIDTH(16),
    .RST_VAL(CHSEC_HS_CNT_RST)
  ) u_hs_cnt (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .inc(hs_err),
    .rd(rd_hs),
    .q(hs_cnt)
  );
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign lane_err[l] = low_side_pattern_check_on ?
      (ls_pat_valid && lane_pattern_error[l]) : lane_bad_codeword[l];
    chsec_err_counter #(
      .WIDTH(16),
      .RST_VAL(CHSEC_LN_CNT_RST)
    ) u_lane_cnt (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .inc(lane_err[l]),
      .rd(rd_lane[l]),
      .q(lane_cnt[l])
    );
  end

  // ****************************************
  // register read decode
  // ****************************************
  always_comb begin
    case (r_ff.addr)
      CHSEC_OFF_STATUS: rd_word = status_q;
      CHSEC_OFF_HS_CNT: rd_word = hs_cnt;
      CHSEC_OFF_LN0_CNT: rd_word = lane_cnt[0];
      CHSEC_OFF_LN1_CNT: rd_word = lane_cnt[1];
      default: rd_word = CHSEC_UNMAPPED_DATA;
    endcase
  end
  assign mdc_rise = mdc && !r_ff.mdc_q;
  assign hdr_shifted = {r_ff.hdr[12:0], mdio_in};
  assign hdr_st = hdr_shifted[13:12];
  assign hdr_op = hdr_shifted[11:10];
  assign hdr_mine = (hdr_st == CHSEC_ST_C45) && (hdr_shifted[9:5] == PORT_ADDR)
    && (hdr_shifted[4:0] == CHSEC_DEV_ADDR);

  // ****************************************
  // management frame engine
  // ****************************************
  // read data moves just after a sampled mdc rise, so it holds a full mdc period
  always_comb begin
    nxt_r = r_ff;
    rd_status = 1'b0;
    rd_hs = 1'b0;
    rd_lane = '0;
    if (ce) begin
      nxt_r.mdc_q = mdc;
      nxt_r.ber_clr = 1'b0;
      if (mdc_rise) begin
        case (r_ff.state)
          CHSEC_ST_PRE: begin
            if (mdio_in) begin
              if (r_ff.cnt != CHSEC_PRE_LEN) begin
                nxt_r.cnt = r_ff.cnt + 6'h01;
              end
            end else if (r_ff.cnt == CHSEC_PRE_LEN) begin
              nxt_r.state = CHSEC_ST_HDR;
              nxt_r.hdr = hdr_shifted;
              nxt_r.cnt = 6'h01;
            end else begin
              nxt_r.cnt = 6'h00;
            end
          end
          CHSEC_ST_HDR: begin
            nxt_r.hdr = hdr_shifted;
            nxt_r.cnt = r_ff.cnt + 6'h01;
            if (r_ff.cnt == CHSEC_HDR_BITS - 6'h01) begin
              nxt_r.cnt = 6'h00;
              nxt_r.is_rd = 1'b0;
              nxt_r.is_addr = 1'b0;
              if (hdr_st != CHSEC_ST_C45) begin
                nxt_r.state = CHSEC_ST_PRE;
              end else begin
                nxt_r.state = CHSEC_ST_TA;
                if (hdr_mine && (hdr_op == CHSEC_OP_READ || hdr_op == CHSEC_OP_READ_INC)) begin
                  // word is captured here, so the side effects hit this value
                  nxt_r.is_rd = 1'b1;
                  nxt_r.shift = rd_word;
                  rd_status = r_ff.addr == CHSEC_OFF_STATUS;
                  rd_hs = r_ff.addr == CHSEC_OFF_HS_CNT;
                  rd_lane[0] = r_ff.addr == CHSEC_OFF_LN0_CNT;
                  rd_lane[1] = r_ff.addr == CHSEC_OFF_LN1_CNT;
                  nxt_r.ber_clr = r_ff.addr == CHSEC_OFF_HS_CNT;
                  if (hdr_op == CHSEC_OP_READ_INC) begin
                    nxt_r.addr = r_ff.addr + 16'h0001;
                  end
                end else if (hdr_mine && hdr_op == CHSEC_OP_ADDR) begin
                  nxt_r.is_addr = 1'b1;
                end
              end
            end
          end
          CHSEC_ST_TA: begin
            nxt_r.cnt = r_ff.cnt + 6'h01;
            if (r_ff.is_rd && r_ff.cnt == 6'h00) begin
              nxt_r.dout = 1'b0;
              nxt_r.oe_n = 1'b0;
            end
            if (r_ff.cnt == CHSEC_TA_BITS - 6'h01) begin
              nxt_r.state = CHSEC_ST_DATA;
              nxt_r.cnt = 6'h00;
              if (r_ff.is_rd) begin
                nxt_r.dout = r_ff.shift[15];
                nxt_r.shift = {r_ff.shift[14:0], 1'b0};
              end
            end
          end
          CHSEC_ST_DATA: begin
            nxt_r.cnt = r_ff.cnt + 6'h01;
            if (r_ff.is_rd) begin
              nxt_r.dout = r_ff.shift[15];
              nxt_r.shift = {r_ff.shift[14:0], 1'b0};
            end else begin
              nxt_r.shift = {r_ff.shift[14:0], mdio_in};
            end
            if (r_ff.cnt == CHSEC_DATA_BITS - 6'h01) begin
              nxt_r.state = CHSEC_ST_PRE;
              nxt_r.cnt = 6'h00;
              nxt_r.oe_n = 1'b1;
              nxt_r.dout = 1'b0;
              nxt_r.is_rd = 1'b0;
              // writes to this group are dropped: every register is read-only
              if (r_ff.is_addr) begin
                nxt_r.addr = {r_ff.shift[14:0], mdio_in};
              end
            end
          end
          default: begin
            nxt_r = MDIO_RST;
          end
        endcase
      end
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_ff <= MDIO_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end
  assign mdio_out = r_ff.dout;
  assign mdio_oe_n = r_ff.oe_n;
  assign hs_ber_clear = r_ff.ber_clr;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb_chk @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_hs_read;
    ce && rd_hs;
  endsequence
  sequence s_clear_pulse;
    hs_ber_clear ##1 !hs_ber_clear;
  endsequence
  property p_ber_clear;
    s_hs_read |=> s_clear_pulse;
  endproperty
  a_ber_clear: assert property (p_ber_clear) else $error("second error byte not cleared");
  property p_lane_unaligned;
    (ce && !low_side_lane_aligned) |=> !status_q[CHSEC_BIT_LANE_ALIGN];
  endproperty
  a_lane_unaligned: assert property (p_lane_unaligned) else $error("lane alignment loss not held");
  property p_sig_lost;
    (ce && high_side_signal_lost) |=> status_q[CHSEC_BIT_SIG_LOST];
  endproperty
  a_sig_lost: assert property (p_sig_lost) else $error("signal loss not latched");
  property p_hs_lock_high;
    (ce && high_side_synth_locked) |=> status_q[CHSEC_BIT_HS_LOCK];
  endproperty
  a_hs_lock_high: assert property (p_hs_lock_high) else $error("synth lock not latch-high");
  property p_func_count;
    (ce && !pseudo_random_test_pin && !high_side_pattern_check_on && high_side_bad_codeword
     && !rd_hs && hs_cnt != 16'hFFFF) |=> (hs_cnt == $past(hs_cnt) + 16'h0001);
  endproperty
  a_func_count: assert property (p_func_count) else $error("bad codeword not counted");
  property p_verify_off_quiet;
    (ce && !pseudo_random_test_pin && high_side_pattern_check_on && !hs_pat_valid && !rd_hs)
    |=> (hs_cnt == $past(hs_cnt));
  endproperty
  a_verify_off_quiet: assert property (p_verify_off_quiet) else $error("count with no pattern");
  property p_prbs_count;
    (ce && pseudo_random_test_pin && hs_pattern_error && !rd_hs && hs_cnt != 16'hFFFF)
    |=> (hs_cnt == $past(hs_cnt) + 16'h0001);
  endproperty
  a_prbs_count: assert property (p_prbs_count) else $error("pin pattern error not counted");
  property p_turn_zero;
    $fell(mdio_oe_n) |-> !mdio_out;
  endproperty
  a_turn_zero: assert property (p_turn_zero) else $error("turnaround bit not zero");
endmodule

// file: chsec_mdio_station.sv
`timescale 1ns/1ps
module chsec_mdio_station #(
  parameter logic [4:0] PRTAD = 5'h00
) (
  input wire logic core_clk,
  output logic mdc,
  output logic mdio_wire,
  input wire logic mdio_out,
  input wire logic mdio_oe_n
);
  import chsec_pkg::*;

  // ****************************************
  // management station, one bit per slot
  // ****************************************
  logic drv_en = 1'b1;
  logic drv_val = 1'b1;

  // released line floats to the pull-up level, never keeps the last value
  assign mdio_wire = !mdio_oe_n ? mdio_out : (drv_en ? drv_val : 1'b1);

  initial mdc = 1'b0;

  // data held across the whole slot, sampled just before the next rise
  task automatic slot(input logic en, input logic val, output logic smp);
    drv_en = en;
    drv_val = val;
    mdc = 1'b0;
    repeat (3) @(negedge core_clk);
    smp = mdio_wire;
    mdc = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] wd,
                       output logic [15:0] rd, output logic ta);
    logic [63:0] fr;
    logic smp;
    fr = {32'hFFFF_FFFF, CHSEC_ST_C45, op, PRTAD, dev, 2'h2, wd};
    for (int i = 0; i < 64; i++) begin
      slot(!(op[1] && i >= 46), fr[63-i], smp);
      if (i == 47) ta = smp;
      if (i >= 48) rd[63-i] = smp;
    end
    // clock stands low between frames
    mdc = 1'b0;
    drv_en = 1'b1;
    drv_val = 1'b1;
    @(negedge core_clk);
  endtask
endmodule

// file: chsec_status_counters_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module chsec_status_counters_tb;
  import chsec_pkg::*;

  // ****************************************
  // bench signals and hookup
  // ****************************************
  localparam logic [4:0] PA = 5'h03;
  localparam logic [15:0] BASE = 16'h5C03;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic mdc, mdio_w, mdio_out, mdio_oe_n, ber;
  logic [15:0] st = 16'h0000;
  logic [5:0] ev = 6'h00;
  logic hs_on = 1'b0;
  logic prbs = 1'b0;
  logic ce = 1'b1;
  logic ls_on = 1'b0;
  logic [2:0] hs_sel = 3'h0;
  logic [2:0] ls_sel = 3'h0;
  int num_errors = 0;
  int compares = 0;
  int bers = 0;
  int ll[5] = '{14, 12, 11, 10, 1};
  int lh[5] = '{13, 7, 6, 5, 4};

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (ber === 1'b1) bers++;

  chsec_status_counters #(.PORT_ADDR(PA), .LANES(2)) dut (
    .core_clk(core_clk), .rst(rst), .ce(ce), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .low_side_lane_aligned(st[14]), .high_side_signal_lost(st[13]),
    .auto_zero_complete(st[12]), .gain_loop_locked(st[11]), .high_side_sync_achieved(st[10]),
    .high_side_bad_codeword(ev[0]), .tx_ctc_underflow(st[7]), .tx_ctc_overflow(st[6]),
    .rx_ctc_underflow(st[5]), .rx_ctc_overflow(st[4]), .low_side_synth_locked(st[1]),
    .high_side_synth_locked(st[0]), .high_side_pattern_check_on(hs_on), .hs_pattern_sel(hs_sel),
    .hs_pattern_error(ev[1]), .pseudo_random_test_pin(prbs), .low_side_pattern_check_on(ls_on),
    .ls_pattern_sel(ls_sel), .lane_bad_codeword(ev[3:2]), .lane_pattern_error(ev[5:4]), .hs_ber_clear(ber));

  chsec_mdio_station #(.PRTAD(PA)) sta (.core_clk(core_clk), .mdc(mdc), .mdio_wire(mdio_w),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));

  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic pulse(input logic [5:0] m, input int n);
    ev = m;
    wt(n);
    ev = 6'h00;
    wt(1);
  endtask

  // address frame, read frame, then data and clear-pulse count
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ta;
    int b0;
    b0 = bers;
    sta.frame(CHSEC_OP_ADDR, CHSEC_DEV_ADDR, a, d, ta);
    sta.frame(CHSEC_OP_READ, CHSEC_DEV_ADDR, 16'h0000, d, ta);
    `CHK(ta, 1'b0)
    `CHK(d, exp)
    `CHK(bers - b0, (a == CHSEC_OFF_HS_CNT) ? 1 : 0)
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [15:0] d;
    logic ta;
    wt(12);
    rst = 1'b0;
    pulse(6'h08, 5);
    rchk(CHSEC_OFF_STATUS, CHSEC_STATUS_RST);
    rchk(CHSEC_OFF_HS_CNT, CHSEC_HS_CNT_RST);
    rchk(CHSEC_OFF_LN0_CNT, CHSEC_LN_CNT_RST);
    rchk(CHSEC_OFF_LN1_CNT, 16'hFFFF);
    rchk(CHSEC_OFF_LN1_CNT, CHSEC_CNT_CLEAR);
    st = BASE;
    wt(3);
    rchk(CHSEC_OFF_STATUS, 16'h0001);
    rchk(CHSEC_OFF_STATUS, BASE);
    foreach (ll[i]) begin
      st[ll[i]] = 1'b0;
      wt(3);
      st[ll[i]] = 1'b1;
      wt(3);
      rchk(CHSEC_OFF_STATUS, BASE & ~(16'h0001 << ll[i]));
      rchk(CHSEC_OFF_STATUS, BASE);
    end
    foreach (lh[i]) begin
      st[lh[i]] = 1'b1;
      wt(3);
      st[lh[i]] = 1'b0;
      wt(3);
      rchk(CHSEC_OFF_STATUS, BASE | (16'h0001 << lh[i]));
      rchk(CHSEC_OFF_STATUS, BASE);
    end
    st[0] = 1'b0;
    wt(3);
    rchk(CHSEC_OFF_STATUS, BASE);
    rchk(CHSEC_OFF_STATUS, 16'h5C02);
    st[0] = 1'b1;
    pulse(6'h01, 5);
    rchk(CHSEC_OFF_STATUS, BASE | 16'h0100);
    rchk(CHSEC_OFF_HS_CNT, 16'h0005);
    rchk(CHSEC_OFF_HS_CNT, CHSEC_CNT_CLEAR);
    pulse(6'h01, 2);
    pulse(6'h04, 3);
    // write must be ignored, foreign device must leave the line released
    sta.frame(CHSEC_OP_ADDR, CHSEC_DEV_ADDR, CHSEC_OFF_HS_CNT, d, ta);
    sta.frame(CHSEC_OP_WRITE, CHSEC_DEV_ADDR, 16'h1234, d, ta);
    sta.frame(CHSEC_OP_READ, 5'h01, 16'h0000, d, ta);
    `CHK({ta, d}, 17'h1FFFF)
    sta.frame(CHSEC_OP_READ_INC, CHSEC_DEV_ADDR, 16'h0000, d, ta);
    `CHK(d, 16'h0002)
    sta.frame(CHSEC_OP_READ, CHSEC_DEV_ADDR, 16'h0000, d, ta);
    `CHK(d, 16'h0003)
    rchk(16'h0013, CHSEC_UNMAPPED_DATA);
    hs_on = 1'b1;
    for (int n = 0; n < 8; n++) begin
      hs_sel = 3'(n);
      pulse(6'h03, 3);
      rchk(CHSEC_OFF_HS_CNT, (n >= 5) ? 16'h0003 : 16'h0000);
    end
    hs_on = 1'b0;
    pulse(6'h02, 3);
    rchk(CHSEC_OFF_HS_CNT, 16'h0000);
    prbs = 1'b1;
    pulse(6'h02, 4);
    rchk(CHSEC_OFF_HS_CNT, 16'h0004);
    prbs = 1'b0;
    // frozen clock enable must swallow the errors
    ce = 1'b0;
    pulse(6'h01, 3);
    ce = 1'b1;
    rchk(CHSEC_OFF_HS_CNT, CHSEC_CNT_CLEAR);
    ls_on = 1'b1;
    for (int n = 0; n < 8; n++) begin
      ls_sel = 3'(n);
      pulse(6'h3C, 2);
      rchk(CHSEC_OFF_LN0_CNT, (n >= 5) ? 16'h0002 : 16'h0000);
      rchk(CHSEC_OFF_LN1_CNT, (n >= 5) ? 16'h0002 : 16'h0000);
    end
    ls_on = 1'b0;
    pulse(6'h38, 2);
    rchk(CHSEC_OFF_LN0_CNT, 16'h0000);
    rchk(CHSEC_OFF_LN1_CNT, 16'h0002);
    // error held through reads: 658 cycles to first capture, 770 per read frame pair
    ev = 6'h04;
    rchk(CHSEC_OFF_LN0_CNT, 16'h0292);
    rchk(CHSEC_OFF_LN0_CNT, 16'h0302);
    ev = 6'h00;
    report_and_stop();
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    report_and_stop();
  end
endmodule
